// ---- verilog/boost_fault_irq_enable_reg.sv ----
// Boost and configuration fault interrupt enable register with set/clear write codes
//
// Behaviour
// - Register sits at offset 0Ah; whole reset value is A028h.
// - Reading a field gives 0h when disabled, 2h when enabled.
// - Writing 1h disables a field's interrupt, writing 3h enables it.
// - Bits 15-14: thermal shutdown enable, resets enabled (2h).
// - Bits 13-12: current-set resistor short enable, resets enabled.
// - Bits 11-10: missing string-configuration resistor enable, resets disabled.
// - Bits 9-8: missing operating-configuration resistor enable, resets disabled.
// - Bits 7-6: missing switching-frequency resistor enable, resets disabled.
// - Bits 5-4: boost over-current enable, resets enabled.
// - Bits 3-2: boost over-voltage-high enable, resets enabled.
`timescale 1ns/1ps

module boost_fault_irq_enable_reg #(
  parameter int unsigned ADDR_W = boost_fault_irq_pkg::ADDR_W
) (
  input  wire logic                                i_sys_clk,
  input  wire logic                                i_rst_n,
  input  wire logic [ADDR_W-1:0]                   i_reg_addr,
  input  wire logic                                i_reg_wr_en,
  input  wire logic [boost_fault_irq_pkg::DATA_W-1:0] i_reg_wr_data,
  input  wire logic                                i_reg_rd_en,
  output logic      [boost_fault_irq_pkg::DATA_W-1:0] o_reg_rd_data,
  output logic                                     o_reg_rd_valid,
  output boost_fault_irq_pkg::irq_enable_t         o_irq_enable
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Offset 0Ah needs at least four address bits
  if (ADDR_W < 4) begin : g_addr_w_check
    $error("ADDR_W too narrow to reach the register offset");
  end

  // Field map assumes a 16-bit word split into 2-bit fields
  if (boost_fault_irq_pkg::DATA_W != 16) begin : g_data_w_check
    $error("register word must be 16 bits");
  end

  if (boost_fault_irq_pkg::FIELD_W != 2) begin : g_field_w_check
    $error("enable fields must be 2 bits wide");
  end

  if (boost_fault_irq_pkg::THERMAL_SHUTDOWN_LSB + boost_fault_irq_pkg::FIELD_W >
      boost_fault_irq_pkg::DATA_W) begin : g_field_pos_check
    $error("top enable field falls outside the register word");
  end

  // Per-field reset states must rebuild the whole-register reset value
  if (build_image(boost_fault_irq_pkg::ENABLE_RESET) !=
      boost_fault_irq_pkg::BOOST_FAULT_IRQ_ENABLE_RESET) begin : g_reset_check
    $error("field reset states disagree with the register reset value");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_enable_code(
    input logic [boost_fault_irq_pkg::FIELD_W-1:0] code
  );
    return code == boost_fault_irq_pkg::WRITE_ENABLE;
  endfunction

  function automatic logic is_disable_code(
    input logic [boost_fault_irq_pkg::FIELD_W-1:0] code
  );
    return code == boost_fault_irq_pkg::WRITE_DISABLE;
  endfunction

  // No request keeps the state, which is why codes 0h and 2h are harmless
  function automatic logic next_enable(
    input logic cur,
    input logic set,
    input logic clr
  );
    logic res;
    res = cur;
    if (set) begin
      res = 1'b1;
    end else if (clr) begin
      res = 1'b0;
    end
    return res;
  endfunction

  function automatic logic [boost_fault_irq_pkg::FIELD_W-1:0] read_code(input logic en);
    return en ? boost_fault_irq_pkg::READ_ENABLED : boost_fault_irq_pkg::READ_DISABLED;
  endfunction

  function automatic logic [boost_fault_irq_pkg::FIELD_W-1:0] field_of(
    input logic [boost_fault_irq_pkg::DATA_W-1:0] data,
    input int unsigned                            lsb
  );
    return data[lsb +: boost_fault_irq_pkg::FIELD_W];
  endfunction

  // Bits with no field, reserved 1-0 included, stay zero
  function automatic logic [boost_fault_irq_pkg::DATA_W-1:0] build_image(
    input boost_fault_irq_pkg::irq_enable_t en
  );
    logic [boost_fault_irq_pkg::DATA_W-1:0] img;
    img = '0;

    // Thermal shutdown, bits 15-14
    img[boost_fault_irq_pkg::THERMAL_SHUTDOWN_LSB +: boost_fault_irq_pkg::FIELD_W] =
      read_code(en.thermal_shutdown_irq_enable);

    // Current-set resistor short, bits 13-12
    img[boost_fault_irq_pkg::CURRENT_RESISTOR_SHORT_LSB +: boost_fault_irq_pkg::FIELD_W] =
      read_code(en.current_resistor_short_irq_enable);

    // String configuration resistor, bits 11-10
    img[boost_fault_irq_pkg::STRING_CONFIG_LSB +: boost_fault_irq_pkg::FIELD_W] =
      read_code(en.string_config_resistor_irq_enable);

    // Operating configuration resistor, bits 9-8
    img[boost_fault_irq_pkg::OPERATING_CONFIG_LSB +: boost_fault_irq_pkg::FIELD_W] =
      read_code(en.operating_config_resistor_irq_enable);

    // Frequency resistor, bits 7-6
    img[boost_fault_irq_pkg::FREQUENCY_RESISTOR_LSB +: boost_fault_irq_pkg::FIELD_W] =
      read_code(en.frequency_resistor_irq_enable);

    // Boost over-current, bits 5-4
    img[boost_fault_irq_pkg::BOOST_OVERCURRENT_LSB +: boost_fault_irq_pkg::FIELD_W] =
      read_code(en.boost_overcurrent_irq_enable);

    // Boost over-voltage high, bits 3-2
    img[boost_fault_irq_pkg::BOOST_OVERVOLTAGE_HIGH_LSB +: boost_fault_irq_pkg::FIELD_W] =
      read_code(en.boost_overvoltage_high_irq_enable);

    return img;
  endfunction

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic hit;

  // Upper address bits above the package width must be zero to match
  assign hit = (i_reg_addr == ADDR_W'(boost_fault_irq_pkg::BOOST_FAULT_IRQ_ENABLE_OFFSET));

  // ----------------------------------------------------------------
  // Enable state
  // ----------------------------------------------------------------
  boost_fault_irq_pkg::irq_enable_t enable_ff;
  boost_fault_irq_pkg::irq_enable_t nxt_enable;

  // ----------------------------------------------------------------
  // Write code decode
  // ----------------------------------------------------------------
  boost_fault_irq_pkg::irq_enable_t wr_set;
  boost_fault_irq_pkg::irq_enable_t wr_clr;
  logic                             wr_hit;

  assign wr_hit = i_reg_wr_en && hit;

  // Codes 0h and 2h raise neither request
  always_comb begin
    wr_set = '0;
    wr_clr = '0;
    if (wr_hit) begin
      // Thermal shutdown, bits 15-14
      wr_set.thermal_shutdown_irq_enable = is_enable_code(
        field_of(i_reg_wr_data, boost_fault_irq_pkg::THERMAL_SHUTDOWN_LSB));
      wr_clr.thermal_shutdown_irq_enable = is_disable_code(
        field_of(i_reg_wr_data, boost_fault_irq_pkg::THERMAL_SHUTDOWN_LSB));

      // Current-set resistor short, bits 13-12
      wr_set.current_resistor_short_irq_enable = is_enable_code(
        field_of(i_reg_wr_data, boost_fault_irq_pkg::CURRENT_RESISTOR_SHORT_LSB));
      wr_clr.current_resistor_short_irq_enable = is_disable_code(
        field_of(i_reg_wr_data, boost_fault_irq_pkg::CURRENT_RESISTOR_SHORT_LSB));

      // String configuration resistor, bits 11-10
      wr_set.string_config_resistor_irq_enable = is_enable_code(
        field_of(i_reg_wr_data, boost_fault_irq_pkg::STRING_CONFIG_LSB));
      wr_clr.string_config_resistor_irq_enable = is_disable_code(
        field_of(i_reg_wr_data, boost_fault_irq_pkg::STRING_CONFIG_LSB));

      // Operating configuration resistor, bits 9-8
      wr_set.operating_config_resistor_irq_enable = is_enable_code(
        field_of(i_reg_wr_data, boost_fault_irq_pkg::OPERATING_CONFIG_LSB));
      wr_clr.operating_config_resistor_irq_enable = is_disable_code(
        field_of(i_reg_wr_data, boost_fault_irq_pkg::OPERATING_CONFIG_LSB));

      // Frequency resistor, bits 7-6
      wr_set.frequency_resistor_irq_enable = is_enable_code(
        field_of(i_reg_wr_data, boost_fault_irq_pkg::FREQUENCY_RESISTOR_LSB));
      wr_clr.frequency_resistor_irq_enable = is_disable_code(
        field_of(i_reg_wr_data, boost_fault_irq_pkg::FREQUENCY_RESISTOR_LSB));

      // Boost over-current, bits 5-4
      wr_set.boost_overcurrent_irq_enable = is_enable_code(
        field_of(i_reg_wr_data, boost_fault_irq_pkg::BOOST_OVERCURRENT_LSB));
      wr_clr.boost_overcurrent_irq_enable = is_disable_code(
        field_of(i_reg_wr_data, boost_fault_irq_pkg::BOOST_OVERCURRENT_LSB));

      // Boost over-voltage high, bits 3-2
      wr_set.boost_overvoltage_high_irq_enable = is_enable_code(
        field_of(i_reg_wr_data, boost_fault_irq_pkg::BOOST_OVERVOLTAGE_HIGH_LSB));
      wr_clr.boost_overvoltage_high_irq_enable = is_disable_code(
        field_of(i_reg_wr_data, boost_fault_irq_pkg::BOOST_OVERVOLTAGE_HIGH_LSB));

      // Reserved bits 1-0 have no storage, so writes there vanish
    end
  end

  always_comb begin
    nxt_enable = enable_ff;
    // Thermal shutdown
    nxt_enable.thermal_shutdown_irq_enable = next_enable(
      enable_ff.thermal_shutdown_irq_enable,
      wr_set.thermal_shutdown_irq_enable,
      wr_clr.thermal_shutdown_irq_enable);

    // Current-set resistor short
    nxt_enable.current_resistor_short_irq_enable = next_enable(
      enable_ff.current_resistor_short_irq_enable,
      wr_set.current_resistor_short_irq_enable,
      wr_clr.current_resistor_short_irq_enable);

    // String configuration resistor
    nxt_enable.string_config_resistor_irq_enable = next_enable(
      enable_ff.string_config_resistor_irq_enable,
      wr_set.string_config_resistor_irq_enable,
      wr_clr.string_config_resistor_irq_enable);

    // Operating configuration resistor
    nxt_enable.operating_config_resistor_irq_enable = next_enable(
      enable_ff.operating_config_resistor_irq_enable,
      wr_set.operating_config_resistor_irq_enable,
      wr_clr.operating_config_resistor_irq_enable);

    // Frequency resistor
    nxt_enable.frequency_resistor_irq_enable = next_enable(
      enable_ff.frequency_resistor_irq_enable,
      wr_set.frequency_resistor_irq_enable,
      wr_clr.frequency_resistor_irq_enable);

    // Boost over-current
    nxt_enable.boost_overcurrent_irq_enable = next_enable(
      enable_ff.boost_overcurrent_irq_enable,
      wr_set.boost_overcurrent_irq_enable,
      wr_clr.boost_overcurrent_irq_enable);

    // Boost over-voltage high
    nxt_enable.boost_overvoltage_high_irq_enable = next_enable(
      enable_ff.boost_overvoltage_high_irq_enable,
      wr_set.boost_overvoltage_high_irq_enable,
      wr_clr.boost_overvoltage_high_irq_enable);
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      enable_ff <= boost_fault_irq_pkg::ENABLE_RESET;
    end else begin
      enable_ff <= nxt_enable;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [boost_fault_irq_pkg::DATA_W-1:0] rd_data_ff;
  logic [boost_fault_irq_pkg::DATA_W-1:0] nxt_rd_data;
  logic                                   rd_valid_ff;
  logic                                   nxt_rd_valid;
  logic [boost_fault_irq_pkg::DATA_W-1:0] reg_image;

  // Image built from live state; a read in the cycle of a write sees old state
  assign reg_image = build_image(enable_ff);

  always_comb begin
    nxt_rd_valid = i_reg_rd_en;
    nxt_rd_data  = rd_data_ff;
    if (i_reg_rd_en) begin
      // Unmapped offsets answer zero rather than stale data
      nxt_rd_data = hit ? reg_image : '0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_data_ff  <= '0;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_data_ff  <= nxt_rd_data;
      rd_valid_ff <= nxt_rd_valid;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_reg_rd_data  = rd_data_ff;
  assign o_reg_rd_valid = rd_valid_ff;
  assign o_irq_enable   = enable_ff;

endmodule // boost_fault_irq_enable_reg

// ---- verilog/boost_fault_irq_pkg.sv ----
// Register map, field layout and codes of the boost fault interrupt enable register
package boost_fault_irq_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned FIELD_W = 2;

  localparam logic [ADDR_W-1:0] BOOST_FAULT_IRQ_ENABLE_OFFSET = 8'h0A;
  localparam logic [DATA_W-1:0] BOOST_FAULT_IRQ_ENABLE_RESET  = 16'hA028;

  // ----------------------------------------------------------------
  // Field positions (low bit of each two-bit field)
  // ----------------------------------------------------------------
  localparam int unsigned THERMAL_SHUTDOWN_LSB      = 14;
  localparam int unsigned CURRENT_RESISTOR_SHORT_LSB = 12;
  localparam int unsigned STRING_CONFIG_LSB          = 10;
  localparam int unsigned OPERATING_CONFIG_LSB       = 8;
  localparam int unsigned FREQUENCY_RESISTOR_LSB     = 6;
  localparam int unsigned BOOST_OVERCURRENT_LSB      = 4;
  localparam int unsigned BOOST_OVERVOLTAGE_HIGH_LSB = 2;
  localparam int unsigned RESERVED_LSB               = 0;

  // ----------------------------------------------------------------
  // Field codes
  // ----------------------------------------------------------------
  localparam logic [FIELD_W-1:0] READ_DISABLED = 2'h0;
  localparam logic [FIELD_W-1:0] READ_ENABLED  = 2'h2;
  localparam logic [FIELD_W-1:0] WRITE_DISABLE = 2'h1;
  localparam logic [FIELD_W-1:0] WRITE_ENABLE  = 2'h3;

  // ----------------------------------------------------------------
  // Enable vector handed to the interrupt logic
  // ----------------------------------------------------------------
  typedef struct packed {
    logic thermal_shutdown_irq_enable;
    logic current_resistor_short_irq_enable;
    logic string_config_resistor_irq_enable;
    logic operating_config_resistor_irq_enable;
    logic frequency_resistor_irq_enable;
    logic boost_overcurrent_irq_enable;
    logic boost_overvoltage_high_irq_enable;
  } irq_enable_t;

  // Per-field reset states, consistent with the whole-register reset value
  localparam irq_enable_t ENABLE_RESET = '{
    thermal_shutdown_irq_enable          : 1'b1,
    current_resistor_short_irq_enable    : 1'b1,
    string_config_resistor_irq_enable    : 1'b0,
    operating_config_resistor_irq_enable : 1'b0,
    frequency_resistor_irq_enable        : 1'b0,
    boost_overcurrent_irq_enable         : 1'b1,
    boost_overvoltage_high_irq_enable    : 1'b1
  };

endpackage

// ---- verification/boost_fault_irq_enable_chk.sv ----
// Port checker for the boost fault interrupt enable register
`timescale 1ns/1ps
module boost_fault_irq_enable_chk #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic                             i_sys_clk,
  input wire logic                             i_rst_n,
  input wire logic [ADDR_W-1:0]                i_reg_addr,
  input wire logic                             i_reg_wr_en,
  input wire logic [15:0]                      i_reg_wr_data,
  input wire logic                             i_reg_rd_en,
  input wire logic [15:0]                      o_reg_rd_data,
  input wire logic                             o_reg_rd_valid,
  input wire boost_fault_irq_pkg::irq_enable_t o_irq_enable
);
  localparam logic [ADDR_W-1:0] OFS = ADDR_W'(boost_fault_irq_pkg::BOOST_FAULT_IRQ_ENABLE_OFFSET);
  function automatic logic [15:0] image(input logic [6:0] e);
    return {e[6], 1'b0, e[5], 1'b0, e[4], 1'b0, e[3], 1'b0, e[2], 1'b0, e[1], 1'b0, e[0], 3'h0};
  endfunction
  // Codes 1h and 3h act, anything else keeps the field
  function automatic logic [6:0] apply(input logic [6:0] e, input logic [15:0] d);
    logic [6:0] n;
    n = e;
    for (int k = 0; k < 7; k++) begin
      if (d[2*k+2 +: 2] == 2'h3) n[k] = 1'b1;
      else if (d[2*k+2 +: 2] == 2'h1) n[k] = 1'b0;
    end
    return n;
  endfunction
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  sequence mapped_rd_s; i_reg_rd_en && (i_reg_addr == OFS); endsequence
  sequence mapped_wr_s; i_reg_wr_en && (i_reg_addr == OFS); endsequence
  rd_pulse_a: assert property (i_reg_rd_en |=> o_reg_rd_valid)
    else $error("read valid missing");
  rd_quiet_a: assert property (!i_reg_rd_en |=> !o_reg_rd_valid)
    else $error("stray read valid");
  rd_image_a: assert property (mapped_rd_s |=> o_reg_rd_data == image($past(o_irq_enable)))
    else $error("read image wrong");
  unmapped_rd_a: assert property (i_reg_rd_en && i_reg_addr != OFS |=> o_reg_rd_data == 16'h0000)
    else $error("unmapped read not zero");
  rd_hold_a: assert property (!i_reg_rd_en |=> $stable(o_reg_rd_data)) else $error("read data moved");
  wr_update_a: assert property (mapped_wr_s |=>
    o_irq_enable == apply($past(o_irq_enable), $past(i_reg_wr_data))) else $error("write wrong");
  wr_hold_a: assert property (!(i_reg_wr_en && i_reg_addr == OFS) |=> $stable(o_irq_enable))
    else $error("enables moved without write");
  rd_codes_a: assert property (o_reg_rd_valid |-> (o_reg_rd_data & 16'h5557) == 16'h0000)
    else $error("reserved or odd bit set");
endmodule // boost_fault_irq_enable_chk
bind boost_fault_irq_enable_reg boost_fault_irq_enable_chk #(.ADDR_W(ADDR_W)) i_chk (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr), .i_reg_wr_en(i_reg_wr_en),
  .i_reg_wr_data(i_reg_wr_data), .i_reg_rd_en(i_reg_rd_en), .o_reg_rd_data(o_reg_rd_data),
  .o_reg_rd_valid(o_reg_rd_valid), .o_irq_enable(o_irq_enable));

// ---- verification/testbench.sv ----
// Self-checking bench for the boost fault interrupt enable register
`timescale 1ns/1ps
module testbench;
  logic        i_sys_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [7:0]  i_reg_addr = 8'h00;
  logic        i_reg_wr_en = 1'b0;
  logic [15:0] i_reg_wr_data = 16'h0000;
  logic        i_reg_rd_en = 1'b0;
  logic [15:0] o_reg_rd_data;
  logic        o_reg_rd_valid;
  boost_fault_irq_pkg::irq_enable_t o_irq_enable;
  logic [15:0] img;
  int          num_errors = 0;
  int          n_checks = 0;
  localparam logic [7:0] REG = 8'h0A;
  logic [7:0]  wa [6] = '{REG, REG, REG, REG, 8'h0B, 8'h8A};
  logic [15:0] wd [6] = '{16'hFFFF, 16'hAAAA, 16'h5555, 16'h0000, 16'hFFFF, 16'hFFFF};
  logic [15:0] we [6] = '{16'hAAA8, 16'hAAA8, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  initial begin
    forever #20 i_sys_clk = ~i_sys_clk;
  end
  boost_fault_irq_enable_reg i_boost_fault_irq_enable_reg (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr),
    .i_reg_wr_en(i_reg_wr_en), .i_reg_wr_data(i_reg_wr_data), .i_reg_rd_en(i_reg_rd_en),
    .o_reg_rd_data(o_reg_rd_data), .o_reg_rd_valid(o_reg_rd_valid), .o_irq_enable(o_irq_enable));
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge i_sys_clk);
    i_reg_addr = a;
    i_reg_wr_data = d;
    i_reg_wr_en = 1'b1;
    @(negedge i_sys_clk);
    i_reg_wr_en = 1'b0;
  endtask
  // Reads one word and also compares the enable vector against the expected image
  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input logic [15:0] im);
    int n;
    n = 0;
    @(negedge i_sys_clk);
    i_reg_addr = a;
    i_reg_rd_en = 1'b1;
    @(negedge i_sys_clk);
    i_reg_rd_en = 1'b0;
    while (o_reg_rd_valid !== 1'b1 && n < 4) begin
      @(negedge i_sys_clk);
      n++;
    end
    if (n == 4) begin
      num_errors++;
      give_verdict();
    end else begin
      check("read data", exp, o_reg_rd_data);
      check("enables", {9'h0, im[15], im[13], im[11], im[9], im[7], im[5], im[3]},
            {9'h0, o_irq_enable});
    end
  endtask
  initial begin
    repeat (12) @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    img = 16'hA028;
    rd(REG, 16'hA028, img);
    $display("test reset value done");
    for (int f = 1; f < 8; f++) begin
      wr(REG, 16'h0003 << (2 * f));
      img[2*f +: 2] = 2'h2;
      rd(REG, img, img);
      wr(REG, 16'h0001 << (2 * f));
      img[2*f +: 2] = 2'h0;
      rd(REG, img, img);
    end
    $display("test single field set and clear done");
    foreach (wa[i]) begin
      wr(wa[i], wd[i]);
      rd(REG, we[i], we[i]);
    end
    rd(8'h0B, 16'h0000, 16'h0000);
    $display("test whole word and unmapped done");
    @(negedge i_sys_clk);
    i_rst_n = 1'b0;
    repeat (2) @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    rd(REG, 16'hA028, 16'hA028);
    $display("test second reset done");
    give_verdict();
  end
endmodule // testbench
